//--- rtl/receiver_mode_clock_control.sv
// Receiver operating mode, start-up timing, clock output and data gating
// Behaviour
// - Divider code 00 keeps clock low; 01, 10, 11 divide oscillator by 3, 6, 12.
// - Clock output runs in standby and active whenever divider code is nonzero.
// - Divided clock output is high for half of each period.
// - Data debounce timing derives from a base tick of oscillator over sixteen; start-up counts hclk cycles.
// - Scaled tick is 8, 4, 2 or 1 base ticks for rate codes 0..3.
// - Sensitivity control low: full sensitivity, data passes ungated.
// - Reduced sensitivity before threshold crossing: data output held low.
// - Latch sets on first crossing; afterwards data passes despite later drops.
// - Rising demodulation select clears the latch, re-arming reduced sensitivity.
// - Gating and latch work the same in amplitude and frequency modes.
// - Enable and receive-enable both low: off, oscillator stopped, no clock.
// - Enable high, receive-enable low: standby, oscillator on, path disabled.
// - Receive-enable and enable high: active, signal path delivers data.
// - Active entry runs synthesizer start-up first, 261 or 269 us by variant.
// - Signal-path start-up length follows the rate code.
// - Data output is 1 for high tone or carrier on, else 0.
// - Demodulation select high picks amplitude, low picks frequency keying.
// - Clock output starts only after oscillator amplitude is good, code nonzero.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module receiver_mode_clock_control
  import rx_ctrl_pkg::*;
#(
  parameter int synth_cycles = SYNTH_HI_CYC,
  parameter int sig_cycles_0 = SIG_HI_CYC_0,
  parameter int sig_cycles_1 = SIG_HI_CYC_1,
  parameter int sig_cycles_2 = SIG_HI_CYC_2,
  parameter int sig_cycles_3 = SIG_HI_CYC_3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic osc_amplitude_ok,
  input wire logic rssi_above,
  input wire logic fsk_tone_high,
  input wire logic ask_carrier_on,
  output logic osc_enable,
  output logic synth_enable,
  output logic sigpath_enable,
  output logic clk_out,
  output logic data_out
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [7:0] ctrl;
    logic [31:0] rdata;
    mode_state_t st;
    logic [15:0] cnt;
    logic [4:0] base_cnt;
    logic [2:0] x_cnt;
    logic sample;
    logic filt;
    logic latch;
    logic demod_prev;
    logic data_out;
    logic osc_en;
    logic synth_en;
    logic sig_en;
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;
  logic addr_phase;
  logic c_enable;
  logic c_rx;
  logic c_sense;
  logic c_demod;
  logic [1:0] c_div;
  logic [1:0] c_rate;
  logic active_req;
  logic base_tick;
  logic xtick;
  logic [2:0] x_last;
  logic [15:0] sig_last;
  logic raw_data;
  logic demod_rise;
  logic latch_set;
  logic latch_clr;
  logic clk_run;
  mode_state_t idle_st;

  assign c_enable = s_reg.ctrl[CTRL_ENABLE];
  assign c_rx = s_reg.ctrl[CTRL_RX];
  assign c_div = s_reg.ctrl[CTRL_DIV_LO +: 2];
  assign c_rate = s_reg.ctrl[CTRL_RATE_LO +: 2];
  assign c_sense = s_reg.ctrl[CTRL_SENSE];
  assign c_demod = s_reg.ctrl[CTRL_DEMOD];

  // ==========================================================
  // Clock output
  always_comb begin
    clk_run = osc_amplitude_ok && (s_reg.st != ST_OFF);
  end

  clock_out_divider u_clk_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(clk_run),
    .div_code(c_div),
    .clk_out(clk_out)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    active_req = c_rx;
    idle_st = c_enable ? ST_STANDBY : ST_OFF;
    // Base and scaled ticks
    base_tick = (s_reg.base_cnt == BASE_TICK_LAST);
    unique case (c_rate)
      2'h0: x_last = XTICK_LAST_0;
      2'h1: x_last = XTICK_LAST_1;
      2'h2: x_last = XTICK_LAST_2;
      2'h3: x_last = XTICK_LAST_3;
    endcase
    xtick = base_tick && (s_reg.x_cnt == x_last);
    unique case (c_rate)
      2'h0: sig_last = 16'(sig_cycles_0 - 1);
      2'h1: sig_last = 16'(sig_cycles_1 - 1);
      2'h2: sig_last = 16'(sig_cycles_2 - 1);
      2'h3: sig_last = 16'(sig_cycles_3 - 1);
    endcase
    // Demodulator choice and its tone mapping
    raw_data = c_demod ? ask_carrier_on : fsk_tone_high;
    demod_rise = c_demod && !s_reg.demod_prev;

    // Bus slave, zero wait states
    if (s_reg.wr_pend) begin
      if (s_reg.wr_addr == ADDR_CTRL) begin
        s_next.ctrl = hwdata[7:0];
      end
    end
    s_next.wr_pend = addr_phase && hwrite;
    s_next.wr_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        ADDR_CTRL: s_next.rdata = {24'h000000, s_reg.ctrl};
        ADDR_STATUS: s_next.rdata = {25'h0000000, clk_out, s_reg.data_out, s_reg.latch,
                                     osc_amplitude_ok, s_reg.st};
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    // Tick counters
    s_next.base_cnt = base_tick ? 5'h00 : s_reg.base_cnt + 5'h01;
    if (base_tick) begin
      s_next.x_cnt = (s_reg.x_cnt >= x_last) ? 3'h0 : s_reg.x_cnt + 3'h1;
    end

    // Debounce: two equal samples on successive scaled ticks
    if (xtick) begin
      s_next.sample = raw_data;
      if (raw_data == s_reg.sample) begin
        s_next.filt = raw_data;
      end
    end

    // Operating state and start-up sequence
    unique case (s_reg.st)
      ST_OFF, ST_STANDBY: begin
        s_next.cnt = 16'h0000;
        s_next.st = active_req ? ST_SYNTH : idle_st;
      end
      ST_SYNTH: begin
        if (!active_req) begin
          s_next.st = idle_st;
        end else if (osc_amplitude_ok) begin
          if (s_reg.cnt == 16'(synth_cycles - 1)) begin
            s_next.st = ST_SIG;
            s_next.cnt = 16'h0000;
          end else begin
            s_next.cnt = s_reg.cnt + 16'h0001;
          end
        end
      end
      ST_SIG: begin
        if (!active_req) begin
          s_next.st = idle_st;
        end else if (c_demod != s_reg.demod_prev) begin
          s_next.cnt = 16'h0000;
        end else if (s_reg.cnt >= sig_last) begin
          s_next.st = ST_READY;
          s_next.cnt = 16'h0000;
        end else begin
          s_next.cnt = s_reg.cnt + 16'h0001;
        end
      end
      ST_READY: begin
        s_next.cnt = 16'h0000;
        if (!active_req) begin
          s_next.st = idle_st;
        end else if (c_demod != s_reg.demod_prev) begin
          s_next.st = ST_SIG;
        end
      end
      default: begin
        s_next.st = ST_OFF;
        s_next.cnt = 16'h0000;
      end
    endcase
    s_next.demod_prev = c_demod;

    // Sensitivity latch, same for both demodulators; set beats clear
    latch_set = c_sense && rssi_above && s_reg.sig_en;
    latch_clr = demod_rise || !s_reg.sig_en;
    s_next.latch = latch_set || (s_reg.latch && !latch_clr);

    // Data output gating
    if (s_reg.st == ST_READY && (!c_sense || s_reg.latch)) begin
      s_next.data_out = s_reg.filt;
    end else begin
      s_next.data_out = 1'b0;
    end

    // Analog block enables follow the next state
    s_next.osc_en = (s_next.st != ST_OFF);
    s_next.synth_en = (s_next.st == ST_SYNTH) || (s_next.st == ST_SIG)
                      || (s_next.st == ST_READY);
    s_next.sig_en = (s_next.st == ST_SIG) || (s_next.st == ST_READY);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{wr_pend: 1'b0, wr_addr: 8'h00, ctrl: CTRL_RESET, rdata: 32'h00000000,
                 st: ST_OFF, cnt: 16'h0000, base_cnt: 5'h00, x_cnt: 3'h0,
                 sample: 1'b0, filt: 1'b0, latch: 1'b0, demod_prev: 1'b0,
                 data_out: 1'b0, osc_en: 1'b0, synth_en: 1'b0, sig_en: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign osc_enable = s_reg.osc_en;
  assign synth_enable = s_reg.synth_en;
  assign sigpath_enable = s_reg.sig_en;
  assign data_out = s_reg.data_out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_off_mode_entry: assert property (!c_enable && !c_rx |=> s_reg.st == ST_OFF
      && !osc_enable)
    else $error("off request did not stop the oscillator");
  a_standby_no_path: assert property (c_enable && !c_rx |=> !sigpath_enable
      && osc_enable)
    else $error("standby left signal path on or oscillator off");
  a_synth_before_sig: assert property (s_reg.st == ST_SYNTH && s_next.st == ST_SIG
      |-> s_reg.cnt == 16'(synth_cycles - 1) && synth_enable)
    else $error("signal path start-up began before synthesizer time");
  a_gate_data_low: assert property (c_sense && !s_reg.latch |=> !data_out)
    else $error("data passed before strength threshold crossing");
  a_latch_holds: assert property (s_reg.latch && !demod_rise && s_reg.sig_en
      && !rssi_above |=> s_reg.latch)
    else $error("sensitivity latch dropped with falling strength");
  a_latch_rearm: assert property (demod_rise && !(c_sense && rssi_above)
      |=> !s_reg.latch)
    else $error("demodulation select pulse did not clear latch");
  a_full_sens_pass: assert property (!c_sense && s_reg.st == ST_READY
      |=> data_out == $past(s_reg.filt))
    else $error("ungated data not passed at full sensitivity");
  a_base_tick_rate: assert property (base_tick |-> ##32 base_tick)
    else $error("base tick period wrong");
  a_xtick_rate0: assert property (
      xtick && c_rate == 2'h0 |-> ##32 (!xtick || c_rate != 2'h0))
    else $error("scaled tick too frequent for rate code 0");
  a_xtick_rate3: assert property (
      xtick && c_rate == 2'h3 |-> ##32 (xtick || c_rate != 2'h3))
    else $error("scaled tick missing for rate code 3");
  a_ready_path_on: assert property (
      s_reg.st == ST_READY |-> sigpath_enable && synth_enable && osc_enable)
    else $error("ready state without receive path enables");
  a_idle_data_low: assert property (s_reg.st != ST_READY |=> !data_out)
    else $error("data output active outside ready state");
  a_clk_wait_osc: assert property (!osc_amplitude_ok && !clk_out |=> !clk_out)
    else $error("clock output started without oscillator amplitude");
  a_latch_path_off: assert property (!sigpath_enable |=> !s_reg.latch)
    else $error("sensitivity latch set while signal path off");

endmodule

//--- rtl/rx_ctrl_pkg.sv
// Constants and types shared by the receiver mode and clock control block
package rx_ctrl_pkg;

  // ==========================================================
  // Clock and oscillator
  localparam int CLK_FREQ_MHZ = 25;
  localparam int XTO_HCLK_PER_CYCLE = 2;
  localparam int BASE_TICK_XTO_CYCLES = 16;
  localparam int BASE_TICK_HCLK = BASE_TICK_XTO_CYCLES * XTO_HCLK_PER_CYCLE;
  localparam logic [4:0] BASE_TICK_LAST = 5'(BASE_TICK_HCLK - 1);
  localparam int DIV_RATIO_1 = 3;
  localparam int DIV_RATIO_2 = 6;
  localparam int DIV_RATIO_3 = 12;
  localparam logic [3:0] HALF_DIV_1 = 4'(DIV_RATIO_1 * XTO_HCLK_PER_CYCLE / 2);
  localparam logic [3:0] HALF_DIV_2 = 4'(DIV_RATIO_2 * XTO_HCLK_PER_CYCLE / 2);
  localparam logic [3:0] HALF_DIV_3 = 4'(DIV_RATIO_3 * XTO_HCLK_PER_CYCLE / 2);
  localparam logic [1:0] DIV_CODE_OFF = 2'h0;

  // ==========================================================
  // Scaled tick, base ticks per scaled tick for rate codes 0..3
  localparam logic [2:0] XTICK_LAST_0 = 3'h7;
  localparam logic [2:0] XTICK_LAST_1 = 3'h3;
  localparam logic [2:0] XTICK_LAST_2 = 3'h1;
  localparam logic [2:0] XTICK_LAST_3 = 3'h0;

  // ==========================================================
  // Start-up times in microseconds and in hclk cycles, both band variants
  localparam int SYNTH_HI_US = 261;
  localparam int SYNTH_LO_US = 269;
  localparam int SIG_HI_US_0 = 1096;
  localparam int SIG_HI_US_1 = 644;
  localparam int SIG_HI_US_2 = 417;
  localparam int SIG_HI_US_3 = 304;
  localparam int SIG_LO_US_0 = 1132;
  localparam int SIG_LO_US_1 = 665;
  localparam int SIG_LO_US_2 = 431;
  localparam int SIG_LO_US_3 = 324;
  localparam int SYNTH_HI_CYC = SYNTH_HI_US * CLK_FREQ_MHZ;
  localparam int SYNTH_LO_CYC = SYNTH_LO_US * CLK_FREQ_MHZ;
  localparam int SIG_HI_CYC_0 = SIG_HI_US_0 * CLK_FREQ_MHZ;
  localparam int SIG_HI_CYC_1 = SIG_HI_US_1 * CLK_FREQ_MHZ;
  localparam int SIG_HI_CYC_2 = SIG_HI_US_2 * CLK_FREQ_MHZ;
  localparam int SIG_HI_CYC_3 = SIG_HI_US_3 * CLK_FREQ_MHZ;
  localparam int SIG_LO_CYC_0 = SIG_LO_US_0 * CLK_FREQ_MHZ;
  localparam int SIG_LO_CYC_1 = SIG_LO_US_1 * CLK_FREQ_MHZ;
  localparam int SIG_LO_CYC_2 = SIG_LO_US_2 * CLK_FREQ_MHZ;
  localparam int SIG_LO_CYC_3 = SIG_LO_US_3 * CLK_FREQ_MHZ;

  // ==========================================================
  // Register map and fields
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_RX = 1;
  localparam int CTRL_DIV_LO = 2;
  localparam int CTRL_RATE_LO = 4;
  localparam int CTRL_SENSE = 6;
  localparam int CTRL_DEMOD = 7;
  localparam int STAT_STATE_LO = 0;
  localparam int STAT_OSC_OK = 3;
  localparam int STAT_LATCH = 4;
  localparam int STAT_DATA = 5;
  localparam int STAT_CLK_RUN = 6;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  // ==========================================================
  // Operating states, Gray coded along the start-up path
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_STANDBY = 3'h1,
    ST_SYNTH = 3'h3,
    ST_SIG = 3'h2,
    ST_READY = 3'h6
  } mode_state_t;

endpackage

//--- rtl/clock_out_divider.sv
// Divided clock output generator with glitch-free ratio changes
`timescale 1ns/1ps
module clock_out_divider
  import rx_ctrl_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [1:0] div_code,
  output logic clk_out
);

  typedef struct packed {
    logic [1:0] code;
    logic [3:0] cnt;
    logic out;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;
  logic [1:0] eff_code;

  function automatic logic [3:0] half_of(input logic [1:0] c);
    logic [3:0] h;
    h = HALF_DIV_3;
    unique case (c)
      2'h1: h = HALF_DIV_1;
      2'h2: h = HALF_DIV_2;
      2'h3: h = HALF_DIV_3;
      2'h0: h = HALF_DIV_3;
    endcase
    return h;
  endfunction

  // ==========================================================
  // Half-period counter
  always_comb begin
    eff_code = run ? div_code : DIV_CODE_OFF;
    s_next = s_reg;
    if (s_reg.code == DIV_CODE_OFF) begin
      // Idle low; a new ratio starts with a full high half
      s_next.code = eff_code;
      s_next.out = (eff_code != DIV_CODE_OFF);
      s_next.cnt = 4'h0;
    end else if (s_reg.cnt == half_of(s_reg.code) - 4'h1) begin
      s_next.cnt = 4'h0;
      if (s_reg.out) begin
        s_next.out = 1'b0;
      end else begin
        // Ratio changes only at a period boundary
        s_next.code = eff_code;
        s_next.out = (eff_code != DIV_CODE_OFF);
      end
    end else begin
      s_next.cnt = s_reg.cnt + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clk_out = s_reg.out;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_clk_off_low: assert property (s_reg.code == DIV_CODE_OFF |-> !s_reg.out)
    else $error("clock output high while divider is off");
  a_clk_high_half: assert property ($rose(s_reg.out) |-> s_reg.out [*3])
    else $error("clock high phase shorter than smallest half period");
  a_clk_low_half: assert property ($fell(s_reg.out) && s_reg.code != DIV_CODE_OFF
      |-> !s_reg.out [*3])
    else $error("clock low phase shorter than smallest half period");

endmodule

//--- testbench/rf_front_model.sv
// Behavioural model of the radio front end beside the control block
`timescale 1ns/1ps
module rf_front_model #(
  parameter int osc_start = 10
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic osc_enable,
  input wire logic sigpath_enable,
  input wire logic data_bit,
  input wire logic rssi_level,
  output logic osc_amplitude_ok,
  output logic rssi_above,
  output logic fsk_tone_high,
  output logic ask_carrier_on
);
  int cnt;
  logic noise;

  // ==========================================================
  // Oscillator start-up delay, toggling noise while path is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      noise <= 1'b0;
    end else begin
      noise <= ~noise;
      if (!osc_enable) begin
        cnt <= 0;
      end else if (cnt < osc_start) begin
        cnt <= cnt + 1;
      end
    end
  end

  assign osc_amplitude_ok = osc_enable && (cnt == osc_start);
  assign rssi_above = sigpath_enable ? rssi_level : 1'b0;
  assign fsk_tone_high = sigpath_enable ? data_bit : noise;
  assign ask_carrier_on = sigpath_enable ? data_bit : ~noise;
endmodule

//--- testbench/tb.sv
// Self-checking testbench of the receiver mode and clock control block
`timescale 1ns/1ps
module tb;
  import rx_ctrl_pkg::*;
  typedef struct packed {logic [31:0] mask; logic [31:0] val;} note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, osc_amplitude_ok, rssi_above, fsk_tone_high, ask_carrier_on;
  logic osc_enable, synth_enable, sigpath_enable, clk_out, data_out;
  logic data_bit = 1'b0;
  logic rssi_level = 1'b0;
  logic rd_phase = 1'b0;
  logic [31:0] seed = 32'hb18b;
  note_t exp_q[$];
  note_t cur;
  int fail_count = 0;
  int n_tests = 0;
  int k, h, l, c;
  int ratio[4] = '{0, DIV_RATIO_1, DIV_RATIO_2, DIV_RATIO_3};
  logic [7:0] d;

  receiver_mode_clock_control #(.synth_cycles(20), .sig_cycles_0(40), .sig_cycles_1(30),
    .sig_cycles_2(20), .sig_cycles_3(10)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_amplitude_ok(osc_amplitude_ok),
    .rssi_above(rssi_above), .fsk_tone_high(fsk_tone_high), .ask_carrier_on(ask_carrier_on),
    .osc_enable(osc_enable), .synth_enable(synth_enable), .sigpath_enable(sigpath_enable),
    .clk_out(clk_out), .data_out(data_out));

  rf_front_model front_u (
    .hclk(hclk), .hresetn(hresetn), .osc_enable(osc_enable),
    .sigpath_enable(sigpath_enable), .data_bit(data_bit), .rssi_level(rssi_level),
    .osc_amplitude_ok(osc_amplitude_ok), .rssi_above(rssi_above),
    .fsk_tone_high(fsk_tone_high), .ask_carrier_on(ask_carrier_on));

  // ==========================================================
  // Reporting
  task final_report;
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task give_up;
    fail_count++;
    final_report;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  // ==========================================================
  // Bus master and helpers
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) give_up;
  endtask

  task wc(input logic [7:0] v);
    @(posedge hclk);
    seed = xs(seed);
    hsel <= 1'b1;
    haddr <= 32'(ADDR_CTRL);
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b1;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= {seed[31:8], v};
    wait_ready;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] val);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= HTRANS_NONSEQ;
    hwrite <= 1'b0;
    wait_ready;
    htrans <= 2'h0;
    rd_phase <= 1'b1;
    exp_q.push_back({mask, val});
    wait_ready;
    rd_phase <= 1'b0;
  endtask

  task automatic wait_lvl(ref logic s, input logic v, output int n);
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (s !== v && n < 200);
    if (n >= 200) give_up;
  endtask

  task meas(input int half);
    wait_lvl(clk_out, 1'b0, k);
    wait_lvl(clk_out, 1'b1, k);
    wait_lvl(clk_out, 1'b0, k);
    wait_lvl(clk_out, 1'b1, k);
    wait_lvl(clk_out, 1'b0, h);
    wait_lvl(clk_out, 1'b1, l);
    check(32'(h), 32'(half), "clk_out high");
    check(32'(l), 32'(half), "clk_out low");
  endtask

  task quiet(input int n);
    h = 0;
    repeat (n) begin
      @(negedge hclk);
      if (clk_out !== 1'b0) h++;
    end
  endtask

  always @(posedge hclk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      cur = exp_q.pop_front();
      check(hrdata & cur.mask, cur.val & cur.mask, "hrdata");
      check(32'(hresp), 32'h0, "hresp");
    end
  end

  initial begin
    forever #20 hclk = ~hclk;
  end

  initial begin
    #(40 * 60000);
    give_up;
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(ADDR_CTRL, 32'hffffffff, 32'h0);
    rd(ADDR_STATUS, 32'h7f, 32'h0);
    check(32'(clk_out), 32'h0, "clk_out");
    wc(8'h05);
    for (int i = 0; i < 8; i++) begin
      @(negedge hclk);
      if (osc_amplitude_ok !== 1'b1) check(32'(clk_out), 32'h0, "clk_out early");
    end
    rd(ADDR_CTRL, 32'hffffffff, 32'h05);
    for (c = 1; c < 4; c++) begin
      wc(8'h01 | 8'(c << 2));
      meas(ratio[c] * XTO_HCLK_PER_CYCLE / 2);
    end
    wc(8'h01);
    cyc(30);
    quiet(40);
    check(32'(h), 32'h0, "clk_out off");
    wc(8'h0d);
    wc(8'h00);
    cyc(30);
    quiet(40);
    check(32'(h), 32'h0, "clk_out in off");
    check(32'(osc_enable), 32'h0, "osc_enable");
    wc(8'h31);
    cyc(15);
    wc(8'h33);
    wait_lvl(sigpath_enable, 1'b1, k);
    check(32'(k >= 20 && k <= 25), 32'h1, "synth phase length");
    cyc(14);
    rd(ADDR_STATUS, 32'h7, 32'(ST_READY));
    check(32'(synth_enable), 32'h1, "synth_enable");
    wc(8'h37);
    meas(ratio[1] * XTO_HCLK_PER_CYCLE / 2);
    for (int m = 0; m < 2; m++) begin
      d = m ? 8'h80 : 8'h00;
      wc(8'h37 | d);
      cyc(40);
      for (int j = 0; j < 4; j++) begin
        seed = xs(seed);
        data_bit <= seed[0];
        cyc(110);
        check(32'(data_out), 32'(seed[0]), "data_out");
      end
    end
    for (int m = 0; m < 2; m++) begin
      d = m ? 8'h80 : 8'h00;
      wc(8'h71 | d);
      wc(8'h73 | d);
      rssi_level <= 1'b0;
      data_bit <= 1'b1;
      cyc(150);
      check(32'(data_out), 32'h0, "data_out gated");
      rd(ADDR_STATUS, 32'h10, 32'h0);
      rssi_level <= 1'b1;
      cyc(3);
      rssi_level <= 1'b0;
      cyc(110);
      check(32'(data_out), 32'h1, "data_out latched");
      rd(ADDR_STATUS, 32'h10, 32'h10);
      wc(8'h73 | (d ^ 8'h80));
      wc(8'h73 | d);
      cyc(150);
      check(32'(data_out), 32'h0, "data_out rearmed");
      rd(ADDR_STATUS, 32'h10, 32'h0);
    end
    cyc(4);
    final_report;
  end
endmodule
